/* File: rtl/fpu_unlock.sv */
// fpu_unlock.sv: flash write protection, page unlock and sector protect
// assumes: strobes synchronous to mclk_in, one cycle per software access
`include "fpu_defines.svh"
`default_nettype none
module fpu_unlock #(
  parameter int FLASH_PAGES = 2,
  parameter int PAGE_BYTES  = 512
) (
  input  wire logic               mclk_in,
  input  wire logic               srst_in,
  input  wire logic               flash_write_protect_option_in,
  input  wire fpu_pkg::fpu_wr_s   wr_in,
  input  wire logic               byte_wr_in,
  input  wire logic [15:0]        byte_addr_in,
  input  wire logic               dbg_mass_erase_in,
  output logic [7:0]              secprot_out,
  output logic [4:0]              state_out,
  output logic [7:0]              page_out,
  output fpu_pkg::fpu_go_s        go_out,
  output logic                    mass_erase_out,
  output logic                    refused_out
);
  localparam int FLASH_BYTES = FLASH_PAGES * PAGE_BYTES;
  // sector never smaller than a page
  localparam int SECT_RAW = FLASH_BYTES / `FPU_SECT_MAX;
  localparam int SECT_BYTES = (SECT_RAW < PAGE_BYTES) ? PAGE_BYTES
                                                      : SECT_RAW;
  localparam int PAGE_SHIFT = $clog2(PAGE_BYTES);
  localparam int SECT_SHIFT = $clog2(SECT_BYTES);

  typedef struct packed {
    fpu_pkg::fpu_state_e st;
    logic [7:0]          page;
    logic [7:0]          secprot;
    logic                programmed;
    fpu_pkg::fpu_go_s    go;
    logic                mass;
    logic                refused;
  } fpu_regs_s;

  fpu_regs_s r_q;
  fpu_regs_s r_d;

  // sector index of a page, reused for erase and program checks
  function automatic logic [2:0] sect_of_page(input logic [7:0] pg);
    logic [31:0] a;
    a = 32'(pg) << PAGE_SHIFT;
    sect_of_page = 3'(a >> SECT_SHIFT);
  endfunction

  function automatic logic [7:0] page_of_addr(input logic [15:0] ad);
    page_of_addr = 8'(ad >> PAGE_SHIFT);
  endfunction

  function automatic logic is_key_first(input logic [7:0] v);
    is_key_first = (v == `FPU_KEY_FIRST);
  endfunction

  function automatic logic is_key_second(input logic [7:0] v);
    is_key_second = (v == `FPU_KEY_SECOND);
  endfunction

  function automatic logic is_erase_cmd(input logic [7:0] v);
    is_erase_cmd = (v == `FPU_CMD_ERASE);
  endfunction

  function automatic logic is_secprot_cmd(input logic [7:0] v);
    is_secprot_cmd = (v == `FPU_CMD_SECPROT);
  endfunction

  // reset image: locked, page 0, no protection, no pulses
  function automatic fpu_regs_s reset_regs();
    fpu_regs_s v;
    v            = '0;
    v.st         = fpu_pkg::ST_LOCKED;
    v.page       = `FPU_PAGE_RST;
    v.secprot    = `FPU_SECPROT_RST;
    v.programmed = 1'b0;
    v.go         = '0;
    v.mass       = 1'b0;
    v.refused    = 1'b0;
    reset_regs   = v;
  endfunction

  // one event per cycle: control beats page select beats byte write
  logic                     ev_ctl;
  logic                     ev_psel;
  logic                     ev_byte;
  logic                     cmd_key1;
  logic                     cmd_key2;
  logic                     cmd_erase;
  logic                     cmd_secprot;
  logic                     opt_ok;
  logic                     sect_ok;
  logic [`FPU_SECT_MAX-1:0] sect_hit;
  logic [`FPU_SECT_MAX-1:0] sect_blk;
  logic [7:0]               secprot_or;
  logic                     page_same;
  logic                     addr_in_page;
  logic                     erase_ask;
  logic                     erase_ok;
  logic                     prog_ok;

  assign ev_ctl       = wr_in.ctl_wr;
  assign ev_psel      = !wr_in.ctl_wr && wr_in.psel_wr;
  assign ev_byte      = !wr_in.ctl_wr && !wr_in.psel_wr && byte_wr_in;
  assign cmd_key1     = is_key_first(wr_in.wdata);
  assign cmd_key2     = is_key_second(wr_in.wdata);
  assign cmd_erase    = is_erase_cmd(wr_in.wdata);
  assign cmd_secprot  = is_secprot_cmd(wr_in.wdata);
  assign opt_ok       = (flash_write_protect_option_in ==
                         `FPU_OPT_ENABLED);
  assign page_same    = (wr_in.wdata == r_q.page);
  assign addr_in_page = (page_of_addr(byte_addr_in) == r_q.page);
  assign sect_ok      = ~|sect_blk;
  // an erase after bytes were programmed only relocks
  assign erase_ask    = cmd_erase && !r_q.programmed;
  assign erase_ok     = erase_ask && opt_ok && sect_ok;
  assign prog_ok      = addr_in_page && opt_ok && sect_ok;

  // one comparator per sector keeps the protect check a flat OR
  genvar s;
  generate
    for (s = 0; s < `FPU_SECT_MAX; s = s + 1) begin : g_sect
      assign sect_hit[s]   = (sect_of_page(r_q.page) == 3'(s));
      assign sect_blk[s]   = sect_hit[s] & r_q.secprot[s];
      // set-only: a zero written never clears a protect bit
      assign secprot_or[s] = r_q.secprot[s] | wr_in.wdata[s];
    end
  endgenerate

  always_comb begin
    r_d             = r_q;
    r_d.go.erase_go = 1'b0;
    r_d.go.prog_go  = 1'b0;
    r_d.refused     = 1'b0;
    // only the debug port may start a mass erase, never a user write
    r_d.mass        = dbg_mass_erase_in;
    case (r_q.st)
      fpu_pkg::ST_LOCKED: begin
        if (ev_ctl) begin
          if (cmd_key1) begin
            r_d.st = fpu_pkg::ST_KEY1;
          end else if (cmd_secprot) begin
            r_d.st = fpu_pkg::ST_SECSEL;
          end else begin
            r_d.st = fpu_pkg::ST_LOCKED;
          end
        end else if (ev_psel) begin
          r_d.page = wr_in.wdata;
        end else if (ev_byte) begin
          r_d.refused = 1'b1;
        end
      end
      fpu_pkg::ST_KEY1: begin
        if (ev_ctl) begin
          if (cmd_key2) begin
            r_d.st = fpu_pkg::ST_KEY2;
          end else begin
            r_d.st = fpu_pkg::ST_LOCKED;
          end
        end else if (ev_psel) begin
          // rewriting page select mid-key drops the sequence
          r_d.st   = fpu_pkg::ST_LOCKED;
          r_d.page = wr_in.wdata;
        end else if (ev_byte) begin
          r_d.refused = 1'b1;
        end
      end
      fpu_pkg::ST_KEY2: begin
        if (ev_ctl) begin
          r_d.st = fpu_pkg::ST_LOCKED;
        end else if (ev_psel) begin
          if (page_same) begin
            // fresh unlock: a stale program mark would block the erase
            r_d.st         = fpu_pkg::ST_UNLOCK;
            r_d.programmed = 1'b0;
          end else begin
            r_d.st = fpu_pkg::ST_LOCKED;
          end
        end else if (ev_byte) begin
          r_d.refused = 1'b1;
        end
      end
      fpu_pkg::ST_UNLOCK: begin
        if (ev_ctl) begin
          r_d.st         = fpu_pkg::ST_LOCKED;
          r_d.programmed = 1'b0;
          if (erase_ok) begin
            r_d.go.erase_go = 1'b1;
            r_d.go.page     = r_q.page;
          end else if (erase_ask) begin
            r_d.refused = 1'b1;
          end
        end else if (ev_psel) begin
          r_d.st   = fpu_pkg::ST_LOCKED;
          r_d.page = wr_in.wdata;
        end else if (ev_byte) begin
          if (prog_ok) begin
            r_d.go.prog_go = 1'b1;
            r_d.go.page    = r_q.page;
            r_d.programmed = 1'b1;
          end else begin
            r_d.refused = 1'b1;
          end
        end
      end
      fpu_pkg::ST_SECSEL: begin
        if (ev_ctl) begin
          r_d.st = fpu_pkg::ST_LOCKED;
        end else if (ev_psel) begin
          r_d.secprot = secprot_or;
        end else if (ev_byte) begin
          r_d.refused = 1'b1;
        end
      end
      default: begin
        r_d.st = fpu_pkg::ST_LOCKED;
      end
    endcase
    if (srst_in) begin
      r_d = reset_regs();
    end
  end

  always_ff @(posedge mclk_in) begin
    r_q <= r_d;
  end

  assign secprot_out    = r_q.secprot;
  assign state_out      = r_q.st;
  assign page_out       = r_q.page;
  assign go_out         = r_q.go;
  assign mass_erase_out = r_q.mass;
  assign refused_out    = r_q.refused;
endmodule
`default_nettype wire

/* File: rtl/fpu_defines.svh */
// fpu_defines.svh: offsets-free constants for the flash protection unlock
// assumes: included by the design file alone, by bare name
`ifndef FPU_DEFINES_SVH
`define FPU_DEFINES_SVH
`define FPU_KEY_FIRST    8'h73
`define FPU_KEY_SECOND   8'h8C
`define FPU_CMD_ERASE    8'h95
`define FPU_CMD_SECPROT  8'h5E
`define FPU_SECT_MAX     8
`define FPU_SECPROT_RST  8'h00
`define FPU_PAGE_RST     8'h00
`define FPU_OPT_ENABLED  1'b1
`endif

/* File: rtl/fpu_pkg.sv */
// fpu_pkg.sv: types for the flash protection unlock
// assumes: fpu_defines.svh is on the include path
`default_nettype none
package fpu_pkg;
  typedef enum logic [4:0] {
    ST_LOCKED  = 5'b00001,
    ST_KEY1    = 5'b00010,
    ST_KEY2    = 5'b00100,
    ST_UNLOCK  = 5'b01000,
    ST_SECSEL  = 5'b10000
  } fpu_state_e;

  // software write strobes from the register file
  typedef struct packed {
    logic       ctl_wr;
    logic       psel_wr;
    logic [7:0] wdata;
  } fpu_wr_s;

  // grants to the flash array
  typedef struct packed {
    logic       erase_go;
    logic       prog_go;
    logic [7:0] page;
  } fpu_go_s;
endpackage
`default_nettype wire

/* File: sim/fpu_unlock_checker.sv */
// checker: port assertions for fpu_unlock
// assumes: bound to fpu_unlock from the bench top file
`default_nettype none
module fpu_unlock_checker (
  input wire logic             mclk_in,
  input wire logic             srst_in,
  input wire logic             flash_write_protect_option_in,
  input wire fpu_pkg::fpu_wr_s wr_in,
  input wire logic             dbg_mass_erase_in,
  input wire logic [7:0]       secprot_out,
  input wire logic [4:0]       state_out,
  input wire logic [7:0]       page_out,
  input wire fpu_pkg::fpu_go_s go_out,
  input wire logic             mass_erase_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  a_reset_lock: assert property (disable iff (1'b0) srst_in |=>
    state_out == 5'h01 && secprot_out == 8'h00) else $error("reset");
  a_mass_dbg: assert property (
    mass_erase_out |-> $past(dbg_mass_erase_in)) else $error("mass");
  a_prog_grant: assert property (go_out.prog_go |->
    $past(state_out) == 5'h08 && $past(flash_write_protect_option_in))
    else $error("prog");
  // the edge just after reset still sees pre-reset bits in $past
  a_prot_keep: assert property (!$past(srst_in) |->
    (secprot_out & $past(secprot_out)) == $past(secprot_out))
    else $error("prot");
  a_key_order: assert property ($rose(state_out[2]) |->
    $past(state_out) == 5'h02 && $past(wr_in.wdata) == 8'h8C)
    else $error("key");
  a_unlock_same: assert property ($rose(state_out[3]) |->
    $past(wr_in.psel_wr) && $past(wr_in.wdata) == $past(page_out))
    else $error("unlock");
  a_erase_ok: assert property (go_out.erase_go |->
    $past(state_out) == 5'h08 && $past(wr_in.wdata) == 8'h95 &&
    !$past(secprot_out[page_out[2:0]])) else $error("erase");
  a_ctl_relock: assert property ($past(wr_in.ctl_wr) &&
    $past(wr_in.wdata) != 8'h95 && $past(state_out) == 5'h08 |->
    state_out == 5'h01) else $error("relock");
endmodule
`default_nettype wire

/* File: sim/fpu_unlock_test.sv */
// bench: unlock, program, erase and protect paths of fpu_unlock
// assumes: rtl files and the checker compiled first
`default_nettype none
module fpu_unlock_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic             mclk_in = 1'b0;
  logic             srst_in = 1'b1;
  logic             opt = 1'b1;
  logic             bwr = 1'b0;
  logic             dbg = 1'b0;
  fpu_pkg::fpu_wr_s wr = '0;
  fpu_pkg::fpu_go_s go;
  logic [7:0]       prot;
  logic [4:0]       st;
  logic [7:0]       pg;
  logic             mass;
  logic             refd;
  int               num_errors = 0;
  int               check_count = 0;
  always #20 mclk_in = ~mclk_in;
  // byte address rides on wdata, so only page 0 is written
  fpu_unlock dut (.mclk_in(mclk_in), .srst_in(srst_in),
    .flash_write_protect_option_in(opt), .wr_in(wr), .byte_wr_in(bwr),
    .byte_addr_in({8'h00, wr.wdata}), .dbg_mass_erase_in(dbg),
    .secprot_out(prot), .state_out(st), .page_out(pg), .go_out(go),
    .mass_erase_out(mass), .refused_out(refd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // k: ctl, psel, byte, debug strobes; one idle cycle follows
  task automatic op(input logic [3:0] k, input logic [7:0] d);
    @(posedge mclk_in);
    wr <= '{k[3], k[2], d};
    bwr <= k[1];
    dbg <= k[0];
    @(posedge mclk_in);
    wr <= '0;
    bwr <= 1'b0;
    dbg <= 1'b0;
    #1;
  endtask
  task automatic ul(input logic [7:0] p);
    op(4'h4, p);
    op(4'h8, 8'h73);
    op(4'h8, 8'h8C);
    op(4'h4, p);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic t_prog;
    op(4'h4, 8'h00);
    op(4'h8, 8'h73);
    chk(st, 8'h02);
    op(4'h8, 8'h8C);
    op(4'h4, 8'h00);
    chk(st, 8'h08);
    op(4'h2, 8'h10);
    chk(go.prog_go, 8'h01);
    op(4'h2, 8'h20);
    chk({go.prog_go, st}, 8'h28);
    op(4'h8, 8'h95);
    chk({go.erase_go, st}, 8'h01);
    ul(8'h00);
    op(4'h2, 8'h30);
    op(4'h4, 8'h00);
    ul(8'h00);
    op(4'h8, 8'h95);
    chk({go.erase_go, st}, 8'h21);
  endtask
  task automatic t_relock;
    ul(8'h01);
    chk(pg, 8'h01);
    op(4'h8, 8'h95);
    chk({go.erase_go, go.page[6:0]}, 8'h81);
    op(4'h4, 8'h00);
    op(4'h8, 8'h73);
    op(4'h8, 8'h8C);
    op(4'h4, 8'h01);
    chk(st, 8'h01);
    ul(8'h00);
    op(4'h8, 8'h5A);
    chk(st, 8'h01);
  endtask
  task automatic t_sector;
    op(4'h8, 8'h5E);
    chk(st, 8'h10);
    op(4'h4, 8'h02);
    op(4'h4, 8'h01);
    chk(prot, 8'h03);
    op(4'h8, 8'h00);
    ul(8'h01);
    op(4'h8, 8'h95);
    chk({go.erase_go, refd}, 8'h01);
  endtask
  task automatic t_option;
    @(posedge mclk_in);
    srst_in <= 1'b1;
    opt <= 1'b0;
    @(posedge mclk_in);
    srst_in <= 1'b0;
    #1;
    chk(prot, 8'h00);
    chk(st, 8'h01);
    ul(8'h00);
    op(4'h2, 8'h05);
    chk({go.prog_go, refd}, 8'h01);
    op(4'h1, 8'h00);
    chk(mass, 8'h01);
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_prog;
    t_relock;
    t_sector;
    t_option;
    stop_test;
  end
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
endmodule
bind fpu_unlock fpu_unlock_checker u_chk (.mclk_in, .srst_in,
  .flash_write_protect_option_in, .wr_in, .dbg_mass_erase_in,
  .secprot_out, .state_out, .page_out, .go_out, .mass_erase_out);
`default_nettype wire
